// ==== hdl/mdp_serial_port.sv ====
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mdp_serial_port #(
   parameter int CHAN_TOP = mdp_pkg::MUX_TOP_CH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [mdp_pkg::REG_AW-1:0] reg_addr,
   input wire logic [mdp_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [mdp_pkg::REG_DW-1:0] reg_rdata,
   input wire logic txd_pin,
   input wire logic rts_n_pin,
   input wire logic dtr_n_pin,
   output logic rxd_pin,
   output logic cts_n_pin,
   output logic dsr_n_pin,
   output logic dcd_n_pin,
   output logic ri_n_pin,
   output logic pin_oe,
   output logic mux_en
);
   import mdp_pkg::*;

   if (CHAN_TOP < 2 || CHAN_TOP > 15) begin : g_chk
      $error("CHAN_TOP must lie in 2..15");
   end

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} mdp_rx_st_t;
   typedef enum logic [2:0] {AB_WAIT, AB_MEAS, AB_SKIP, AB_FRAME, AB_LOCK}
      mdp_ab_st_t;

   mdp_tx_if txif ();

   // pin inputs: three flops, a change counts once flops two and three agree
   logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   assign pin_d = (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 3'h7;
         s2_q <= 3'h7;
         s3_q <= 3'h7;
         pin_q <= 3'h7;
      end else begin
         s1_q <= {dtr_n_pin, rts_n_pin, txd_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end
   logic rx_line, rts_on, dtr_on;
   assign rx_line = pin_q[0];
   assign rts_on = ~pin_q[1];
   assign dtr_on = ~pin_q[2];

   // control state
   logic [3:0] rate_q, rate_d;
   logic auto_q, auto_d;
   mdp_fmt_t fmt_q, fmt_d;
   mdp_flow_t flow_q, flow_d;
   logic dsr_f_q, dsr_f_d, dcd_f_q, dcd_f_d, dtr_f_q, dtr_f_d;
   logic mux_q, mux_d, data_q, data_d, carr_q, carr_d, ring_q, ring_d;
   logic rxv_q, rxv_d, perr_q, perr_d, ferr_q, ferr_d;
   logic dtre_q, dtre_d, dtr_prev_q, xoff_q, xoff_d;
   logic [7:0] rxb_q, rxb_d, txb_q, txb_d, tdat_q, tdat_d;
   logic txp_q, txp_d, tst_q, tst_d, oe_q;
   logic [2:0] ok_q, ok_d;
   logic [16:0] tdiv_q, tdiv_d;
   mdp_fmt_t tfmt_q, tfmt_d;
   logic [REG_DW-1:0] rd_q, rd_d, stat;
   logic cts_n_q, cts_n_d, dsr_n_q, dsr_n_d, dcd_n_q, dcd_n_d;

   // receive and rate detection state
   mdp_rx_st_t rx_q, rx_d;
   mdp_ab_st_t ab_q, ab_d;
   logic [16:0] rcnt_q, rcnt_d;
   logic [3:0] rbit_q, rbit_d, drate_q, drate_d, tot;
   logic [8:0] sh_q, sh_d, al;
   logic stop2_q, stop2_d;
   logic [19:0] acnt_q, acnt_d;
   mdp_fmt_t dfmt_q, dfmt_d, act_fmt;
   logic [3:0] act_rate, nrate;
   logic [16:0] act_div, ndiv;
   logic det, rx_on, deliver, perr_ev, ferr_ev;
   logic [7:0] rdata8;

   // auto format overrides the configured one while autobaud is on
   assign act_rate = auto_q ? drate_q : rate_q;
   assign act_fmt = auto_q ? dfmt_q : fmt_q;
   assign act_div = rate_div(act_rate);
   assign det = auto_q && (ab_q == AB_FRAME);
   assign rx_on = !auto_q || ab_q == AB_FRAME || ab_q == AB_LOCK;
   assign tot = det ? 4'h9 :
      (fmt_seven(act_fmt) ? 4'h7 : 4'h8) + {3'h0, fmt_par(act_fmt)};
   assign al = 9'(sh_q >> (4'h9 - tot));
   assign rdata8 = fmt_seven(act_fmt) ? {1'b0, al[6:0]} : al[7:0];
   assign nrate = pick_rate(acnt_q);
   assign ndiv = rate_div(nrate);

   always_comb begin
      rx_d = rx_q;
      ab_d = ab_q;
      rcnt_d = rcnt_q;
      rbit_d = rbit_q;
      sh_d = sh_q;
      stop2_d = stop2_q;
      acnt_d = acnt_q;
      drate_d = drate_q;
      dfmt_d = dfmt_q;
      deliver = 1'b0;
      perr_ev = 1'b0;
      ferr_ev = 1'b0;
      unique case (rx_q)
         RX_IDLE: if (rx_on && !rx_line) begin
            rx_d = RX_START;
            rcnt_d = act_div >> 1;
         end
         RX_START: if (rcnt_q == 17'h0) begin
            rx_d = rx_line ? RX_IDLE : RX_BITS;
            rcnt_d = act_div;
            rbit_d = 4'h0;
         end else begin
            rcnt_d = rcnt_q - 17'h1;
         end
         RX_BITS: if (rcnt_q == 17'h0) begin
            sh_d = {rx_line, sh_q[8:1]};
            rcnt_d = act_div;
            rbit_d = rbit_q + 4'h1;
            stop2_d = 1'b0;
            if (rbit_q == tot - 4'h1) begin
               rx_d = RX_STOP;
            end
         end else begin
            rcnt_d = rcnt_q - 17'h1;
         end
         RX_STOP: if (rcnt_q == 17'h0) begin
            rcnt_d = act_div;
            if (det) begin
               rx_d = RX_IDLE;
               ab_d = AB_LOCK;
               if (sh_q[7]) begin
                  dfmt_d = (sh_q[7] == ^sh_q[6:0]) ? FMT_7E1 : FMT_7O1;
               end else if (!sh_q[8]) begin
                  dfmt_d = (^sh_q[6:0]) ? FMT_8O1 : FMT_8E1;
               end else begin
                  dfmt_d = FMT_8N1;
               end
            end else if (fmt_two(act_fmt) && !stop2_q && rx_line) begin
               stop2_d = 1'b1;
            end else begin
               rx_d = RX_IDLE;
               deliver = 1'b1;
               ferr_ev = !rx_line;
               perr_ev = fmt_par(act_fmt) &&
                  ((^rdata8 ^ al[fmt_seven(act_fmt) ? 7 : 8]) !=
                   fmt_odd(act_fmt));
            end
         end else begin
            rcnt_d = rcnt_q - 17'h1;
         end
      endcase
      // first start bit gives the rate, second character the format
      if (!auto_q) begin
         ab_d = AB_WAIT;
      end else begin
         unique case (ab_q)
            AB_WAIT: if (!rx_line) begin
               ab_d = AB_MEAS;
               acnt_d = 20'h1;
            end
            AB_MEAS: if (rx_line) begin
               ab_d = AB_SKIP;
               drate_d = nrate;
               acnt_d = (20'(ndiv) << AB_SKIP_BITS / 8 * 3) + 20'(ndiv >> 1);
            end else if (acnt_q != 20'hFFFFF) begin
               acnt_d = acnt_q + 20'h1;
            end
            AB_SKIP: if (acnt_q == 20'h0) begin
               ab_d = AB_FRAME;
            end else begin
               acnt_d = acnt_q - 20'h1;
            end
            AB_FRAME, AB_LOCK: ;
            default: ab_d = AB_WAIT;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_q <= RX_IDLE;
         ab_q <= AB_WAIT;
         rcnt_q <= 17'h0;
         rbit_q <= 4'h0;
         sh_q <= 9'h000;
         stop2_q <= 1'b0;
         acnt_q <= 20'h0;
         drate_q <= RATE_RESET;
         dfmt_q <= FMT_8N1;
      end else begin
         rx_q <= rx_d;
         ab_q <= ab_d;
         rcnt_q <= rcnt_d;
         rbit_q <= rbit_d;
         sh_q <= sh_d;
         stop2_q <= stop2_d;
         acnt_q <= acnt_d;
         drate_q <= drate_d;
         dfmt_q <= dfmt_d;
      end
   end

   always_comb begin
      stat = '0;
      stat[ST_TXBUSY] = txif.busy | txp_q | tst_q | (ok_q != 3'h0);
      stat[ST_RXV] = rxv_q;
      stat[ST_PERR] = perr_q;
      stat[ST_FERR] = ferr_q;
      stat[ST_LOCK] = !auto_q || ab_q == AB_LOCK;
      stat[ST_RTS] = rts_on;
      stat[ST_DTR] = dtr_on;
      stat[ST_DTREVT] = dtre_q;
      stat[ST_RATE +: 4] = act_rate;
      stat[ST_FMT +: 3] = act_fmt;
      stat[ST_CMDIF] = 1'b1;
      stat[ST_CHAN +: 4] = mux_q ? 4'(CHAN_TOP) : MUX_CTRL_CH;
   end

   always_comb begin
      rate_d = rate_q;
      auto_d = auto_q;
      fmt_d = fmt_q;
      flow_d = flow_q;
      dsr_f_d = dsr_f_q;
      dcd_f_d = dcd_f_q;
      dtr_f_d = dtr_f_q;
      mux_d = mux_q;
      data_d = data_q;
      carr_d = carr_q;
      ring_d = ring_q;
      rxv_d = rxv_q;
      perr_d = perr_q;
      ferr_d = ferr_q;
      dtre_d = dtre_q;
      xoff_d = xoff_q;
      rxb_d = rxb_q;
      txb_d = txb_q;
      txp_d = txp_q;
      ok_d = ok_q;
      rd_d = '0;
      tst_d = 1'b0;
      tdat_d = tdat_q;
      tfmt_d = tfmt_q;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: rd_d = REG_DW'({mux_q, dtr_f_q, dcd_f_q, dsr_f_q,
               flow_q, fmt_q, auto_q, rate_q});
            REG_STATUS: rd_d = stat;
            REG_RXDATA: begin
               rd_d = REG_DW'(rxb_q);
               rxv_d = 1'b0;
            end
            REG_LINE: rd_d = REG_DW'({ring_q, carr_q, data_q});
            default: rd_d = '0;
         endcase
      end
      if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: begin
               // only the configurable rates are accepted
               if (reg_wdata[CTRL_RATE +: 4] >= RATE_FIX_MIN &&
                   reg_wdata[CTRL_RATE +: 4] <= RATE_FIX_MAX) begin
                  rate_d = reg_wdata[CTRL_RATE +: 4];
               end
               auto_d = reg_wdata[CTRL_AUTO];
               if (reg_wdata[CTRL_FMT +: 3] <= 3'(FMT_7O1)) begin
                  fmt_d = mdp_fmt_t'(reg_wdata[CTRL_FMT +: 3]);
               end
               if (reg_wdata[CTRL_FLOW +: 2] <= 2'(FLOW_SW)) begin
                  flow_d = mdp_flow_t'(reg_wdata[CTRL_FLOW +: 2]);
               end
               dsr_f_d = reg_wdata[CTRL_DSR];
               dcd_f_d = reg_wdata[CTRL_DCD];
               dtr_f_d = reg_wdata[CTRL_DTR];
               mux_d = reg_wdata[CTRL_MUX];
            end
            REG_STATUS: begin
               perr_d = perr_q & ~reg_wdata[ST_PERR];
               ferr_d = ferr_q & ~reg_wdata[ST_FERR];
               dtre_d = dtre_q & ~reg_wdata[ST_DTREVT];
            end
            REG_TXDATA: if (!txp_q) begin
               txb_d = reg_wdata[7:0];
               txp_d = 1'b1;
            end
            REG_LINE: begin
               data_d = reg_wdata[LINE_DATA];
               carr_d = reg_wdata[LINE_CARR];
               ring_d = reg_wdata[LINE_RING];
            end
            default: ;
         endcase
      end
      // received characters; hardware events win over software clears
      if (deliver) begin
         if (flow_q == FLOW_SW && rdata8 == CHR_XOFF) begin
            xoff_d = 1'b1;
         end else if (flow_q == FLOW_SW && rdata8 == CHR_XON) begin
            xoff_d = 1'b0;
         end else begin
            rxb_d = rdata8;
            rxv_d = 1'b1;
         end
      end
      if (perr_ev) begin
         perr_d = 1'b1;
      end
      if (ferr_ev) begin
         ferr_d = 1'b1;
      end
      if (flow_q != FLOW_SW) begin
         xoff_d = 1'b0;
      end
      // DTR dropping returns to online command mode and answers OK
      if (dtr_f_q && dtr_prev_q && !dtr_on) begin
         data_d = 1'b0;
         dtre_d = 1'b1;
         ok_d = 3'h1;
      end
      // transmit only at character boundaries, so RTS OFF ends within one
      if (!txif.busy && !tst_q && (flow_q != FLOW_HW || rts_on) &&
          (flow_q != FLOW_SW || !xoff_q)) begin
         if (ok_q != 3'h0) begin
            tst_d = 1'b1;
            tdat_d = ok_char(ok_q);
            ok_d = (ok_q == OK_LEN) ? 3'h0 : ok_q + 3'h1;
         end else if (txp_q) begin
            tst_d = 1'b1;
            tdat_d = txb_q;
            txp_d = 1'b0;
         end
         tfmt_d = act_fmt;
      end
      tdiv_d = (!txif.busy || tdiv_q == act_div - 17'h1) ? 17'h0 :
         tdiv_q + 17'h1;
      // CTS shows whether another character can be taken
      cts_n_d = (flow_q == FLOW_HW) ? rxv_q : 1'b0;
      dsr_n_d = dsr_f_q ? !data_q : 1'b0;
      dcd_n_d = dcd_f_q ? !carr_q : 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_q <= RATE_RESET;
         auto_q <= AUTO_RESET;
         fmt_q <= FMT_8N1;
         flow_q <= FLOW_HW;
         dsr_f_q <= FOLLOW_RESET;
         dcd_f_q <= FOLLOW_RESET;
         dtr_f_q <= FOLLOW_RESET;
         mux_q <= MUX_RESET;
         data_q <= 1'b0;
         carr_q <= 1'b0;
         ring_q <= 1'b0;
         rxv_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         dtre_q <= 1'b0;
         dtr_prev_q <= 1'b0;
         xoff_q <= 1'b0;
         rxb_q <= 8'h00;
         txb_q <= 8'h00;
         txp_q <= 1'b0;
         ok_q <= 3'h0;
         rd_q <= '0;
         tst_q <= 1'b0;
         tdat_q <= 8'h00;
         tfmt_q <= FMT_8N1;
         tdiv_q <= 17'h0;
         cts_n_q <= 1'b1;
         dsr_n_q <= 1'b1;
         dcd_n_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         rate_q <= rate_d;
         auto_q <= auto_d;
         fmt_q <= fmt_d;
         flow_q <= flow_d;
         dsr_f_q <= dsr_f_d;
         dcd_f_q <= dcd_f_d;
         dtr_f_q <= dtr_f_d;
         mux_q <= mux_d;
         data_q <= data_d;
         carr_q <= carr_d;
         ring_q <= ring_d;
         rxv_q <= rxv_d;
         perr_q <= perr_d;
         ferr_q <= ferr_d;
         dtre_q <= dtre_d;
         dtr_prev_q <= dtr_on;
         xoff_q <= xoff_d;
         rxb_q <= rxb_d;
         txb_q <= txb_d;
         txp_q <= txp_d;
         ok_q <= ok_d;
         rd_q <= rd_d;
         tst_q <= tst_d;
         tdat_q <= tdat_d;
         tfmt_q <= tfmt_d;
         tdiv_q <= tdiv_d;
         cts_n_q <= cts_n_d;
         dsr_n_q <= dsr_n_d;
         dcd_n_q <= dcd_n_d;
         oe_q <= 1'b1;
      end
   end

   assign txif.start = tst_q;
   assign txif.data = tdat_q;
   assign txif.fmt = tfmt_q;
   assign txif.bit_tick = txif.busy && (tdiv_q == act_div - 17'h1);

   mdp_tx_serializer u_tx (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tx(txif.ser)
   );

   // the five output lines, all but RXD active low
   assign rxd_pin = txif.txd;
   assign cts_n_pin = cts_n_q;
   assign dsr_n_pin = dsr_n_q;
   assign dcd_n_pin = dcd_n_q;
   assign ri_n_pin = !ring_q;
   assign pin_oe = oe_q;
   assign mux_en = mux_q;
   assign reg_rdata = rd_q;
endmodule // mdp_serial_port
`default_nettype wire

// ==== hdl/mdp_pkg.sv ====
//Function
//- nine V.24 lines on the port
//- low means zero bit or ON
//- module is DCE; TXD is input
//- fixed rates 2400..115200, default 115200
//- 1200 and 230400 only by autobaud
//- autobaud active after reset
//- six supported character formats
//- fixed rate default format 8N1
//- autobaud forces auto format, overrides setting
//- flow control hardware, XON/XOFF or none
//- hardware flow control after reset
//- command interface enabled after reset
//- DSR ON in data mode
//- DTR ON-to-OFF: online command, send OK
//- DCD follows carrier status
//- multiplexing off; channel 0 control
//- pins float, then reset level, then enabled
//- CTS ON at init, tracks acceptance
//- RTS OFF stops sending within two chars
//- RXD idle high until data
package mdp_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int BPS_1200 = 1200;
   localparam int BPS_2400 = 2400;
   localparam int BPS_4800 = 4800;
   localparam int BPS_9600 = 9600;
   localparam int BPS_19200 = 19200;
   localparam int BPS_38400 = 38400;
   localparam int BPS_57600 = 57600;
   localparam int BPS_115200 = 115200;
   localparam int BPS_230400 = 230400;
   localparam int RATE_NUM = 9;
   localparam logic [3:0] RATE_FIX_MIN = 4'h1;
   localparam logic [3:0] RATE_FIX_MAX = 4'h7;
   localparam logic [3:0] RATE_RESET = 4'h7;
   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0C;
   localparam logic [7:0] REG_LINE = 8'h10;
   localparam int CTRL_RATE = 0;
   localparam int CTRL_AUTO = 4;
   localparam int CTRL_FMT = 5;
   localparam int CTRL_FLOW = 8;
   localparam int CTRL_DSR = 10;
   localparam int CTRL_DCD = 11;
   localparam int CTRL_DTR = 12;
   localparam int CTRL_MUX = 13;
   localparam int LINE_DATA = 0;
   localparam int LINE_CARR = 1;
   localparam int LINE_RING = 2;
   localparam int ST_TXBUSY = 0;
   localparam int ST_RXV = 1;
   localparam int ST_PERR = 2;
   localparam int ST_FERR = 3;
   localparam int ST_LOCK = 4;
   localparam int ST_RTS = 5;
   localparam int ST_DTR = 6;
   localparam int ST_DTREVT = 7;
   localparam int ST_RATE = 8;
   localparam int ST_FMT = 12;
   localparam int ST_CMDIF = 15;
   localparam int ST_CHAN = 16;
   localparam logic AUTO_RESET = 1'b1;
   localparam logic FOLLOW_RESET = 1'b1;
   localparam logic MUX_RESET = 1'b0;
   localparam logic [7:0] CHR_XON = 8'h11;
   localparam logic [7:0] CHR_XOFF = 8'h13;
   localparam logic [2:0] OK_LEN = 3'h6;
   localparam logic [3:0] MUX_CTRL_CH = 4'h0;
   localparam int MUX_TOP_CH = 6;
   localparam int AB_SKIP_BITS = 8;

   typedef enum logic [2:0] {
      FMT_8N1, FMT_8E1, FMT_8O1, FMT_8N2, FMT_7E1, FMT_7O1
   } mdp_fmt_t;
   typedef enum logic [1:0] {FLOW_NONE, FLOW_HW, FLOW_SW} mdp_flow_t;

   function automatic logic [16:0] rate_div(input logic [3:0] sel);
      case (sel)
         4'h0: rate_div = 17'(CLK_HZ / BPS_1200);
         4'h1: rate_div = 17'(CLK_HZ / BPS_2400);
         4'h2: rate_div = 17'(CLK_HZ / BPS_4800);
         4'h3: rate_div = 17'(CLK_HZ / BPS_9600);
         4'h4: rate_div = 17'(CLK_HZ / BPS_19200);
         4'h5: rate_div = 17'(CLK_HZ / BPS_38400);
         4'h6: rate_div = 17'(CLK_HZ / BPS_57600);
         4'h8: rate_div = 17'(CLK_HZ / BPS_230400);
         default: rate_div = 17'(CLK_HZ / BPS_115200);
      endcase
   endfunction

   // slowest rate whose bit time is at least three quarters matched
   function automatic logic [3:0] pick_rate(input logic [19:0] m);
      logic [19:0] d;
      pick_rate = 4'h8;
      for (int i = RATE_NUM - 1; i >= 0; i--) begin
         d = 20'(rate_div(4'(i)));
         if (m >= d - (d >> 2)) begin
            pick_rate = 4'(i);
         end
      end
   endfunction

   function automatic logic fmt_seven(input mdp_fmt_t f);
      fmt_seven = (f == FMT_7E1) || (f == FMT_7O1);
   endfunction
   function automatic logic fmt_par(input mdp_fmt_t f);
      fmt_par = (f != FMT_8N1) && (f != FMT_8N2);
   endfunction
   function automatic logic fmt_odd(input mdp_fmt_t f);
      fmt_odd = (f == FMT_8O1) || (f == FMT_7O1);
   endfunction
   function automatic logic fmt_two(input mdp_fmt_t f);
      fmt_two = (f == FMT_8N2);
   endfunction

   function automatic logic [7:0] ok_char(input logic [2:0] idx);
      case (idx)
         3'h3: ok_char = 8'h4F;
         3'h4: ok_char = 8'h4B;
         3'h1, 3'h5: ok_char = 8'h0D;
         default: ok_char = 8'h0A;
      endcase
   endfunction
endpackage

// ==== hdl/mdp_tx_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface mdp_tx_if;
   logic bit_tick;
   logic start;
   logic [7:0] data;
   mdp_pkg::mdp_fmt_t fmt;
   logic busy;
   logic txd;
   modport ctl (output bit_tick, start, data, fmt, input busy, txd);
   modport ser (input bit_tick, start, data, fmt, output busy, txd);
endinterface
`default_nettype wire

// ==== hdl/mdp_tx_serializer.sv ====
`timescale 1ns/10ps
`default_nettype none
module mdp_tx_serializer (
   input wire logic ref_clk,
   input wire logic rst_n,
   mdp_tx_if.ser tx
);
   import mdp_pkg::*;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      mdp_tx_st_t;
   mdp_tx_st_t st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic par_q, par_d;
   logic txd_q, txd_d;
   mdp_fmt_t fmt_q, fmt_d;

   assign tx.busy = (st_q != TX_IDLE);
   assign tx.txd = txd_q;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      par_d = par_q;
      txd_d = txd_q;
      fmt_d = fmt_q;
      unique case (st_q)
         TX_IDLE: begin
            txd_d = 1'b1;
            if (tx.start) begin
               st_d = TX_START;
               sh_d = tx.data;
               fmt_d = tx.fmt;
               par_d = fmt_odd(tx.fmt);
               txd_d = 1'b0;
            end
         end
         TX_START: if (tx.bit_tick) begin
            st_d = TX_DATA;
            cnt_d = 4'h0;
            txd_d = sh_q[0];
            par_d = par_q ^ sh_q[0];
            sh_d = {1'b0, sh_q[7:1]};
         end
         TX_DATA: if (tx.bit_tick) begin
            if (cnt_q == (fmt_seven(fmt_q) ? 4'h6 : 4'h7)) begin
               cnt_d = 4'h0;
               st_d = fmt_par(fmt_q) ? TX_PAR : TX_STOP;
               txd_d = fmt_par(fmt_q) ? par_q : 1'b1;
            end else begin
               cnt_d = cnt_q + 4'h1;
               txd_d = sh_q[0];
               par_d = par_q ^ sh_q[0];
               sh_d = {1'b0, sh_q[7:1]};
            end
         end
         TX_PAR: if (tx.bit_tick) begin
            st_d = TX_STOP;
            txd_d = 1'b1;
         end
         TX_STOP: if (tx.bit_tick) begin
            if (fmt_two(fmt_q) && cnt_q == 4'h0) begin
               cnt_d = 4'h1;
            end else begin
               st_d = TX_IDLE;
            end
         end
         default: st_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= TX_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         par_q <= 1'b0;
         txd_q <= 1'b1;
         fmt_q <= FMT_8N1;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         par_q <= par_d;
         txd_q <= txd_d;
         fmt_q <= fmt_d;
      end
   end
endmodule // mdp_tx_serializer
`default_nettype wire

// ==== verification/mdp_serial_port_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module mdp_serial_port_assertions import mdp_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [REG_DW-1:0] reg_rdata,
   input wire logic rxd_pin,
   input wire logic cts_n_pin,
   input wire logic dcd_n_pin,
   input wire logic ri_n_pin,
   input wire logic pin_oe,
   input wire logic mux_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_rd; !$past(reg_rd) |-> reg_rdata == '0; endproperty
   a_rd: assert property (p_rd) else $error("stray read data");
   property p_oe; $past(rst_n) |-> pin_oe; endproperty
   a_oe: assert property (p_oe) else $error("pins not driven");
   property p_start; $fell(rxd_pin) |=> !rxd_pin [*8]; endproperty
   a_start: assert property (p_start) else $error("short start");
   property p_cts; $rose(rst_n) |=> !cts_n_pin; endproperty
   a_cts: assert property (p_cts) else $error("cts off at init");
   property p_mux;
      $changed(mux_en) |-> $past(reg_wr) && $past(reg_addr) == REG_CTRL;
   endproperty
   a_mux: assert property (p_mux) else $error("mux moved alone");
   property p_dcd; $changed(dcd_n_pin) |-> $past(reg_wr, 1) || $past(reg_wr, 2);
   endproperty
   a_dcd: assert property (p_dcd) else $error("dcd moved alone");
   property p_ri; $changed(ri_n_pin) |-> $past(reg_wr, 1) || $past(reg_wr, 2);
   endproperty
   a_ri: assert property (p_ri) else $error("ri moved alone");
   property p_cmd; reg_rd && reg_addr == REG_STATUS |=> reg_rdata[ST_CMDIF];
   endproperty
   a_cmd: assert property (p_cmd) else $error("command off");
   c_mux: cover property ($rose(mux_en));
   c_tx: cover property ($fell(rxd_pin));
   c_ri: cover property ($fell(ri_n_pin));
endmodule // mdp_serial_port_assertions
bind mdp_serial_port mdp_serial_port_assertions u_chk (.*);
`default_nettype wire

// ==== verification/mdp_dte_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mdp_dte_model (
   input wire logic ref_clk,
   input wire logic rxd_pin,
   output logic txd_pin,
   output logic rts_n_pin,
   output logic dtr_n_pin
);
   initial begin
      txd_pin = 1'h1;
      rts_n_pin = 1'h0;
      dtr_n_pin = 1'h0;
   end
   task automatic set_dtr(input logic v);
      @(posedge ref_clk);
      dtr_n_pin <= v;
   endtask
   // one frame onto txd, lsb first; n bits of f, start bit in f[0]
   task automatic tx_frame(input int div, input int n,
      input logic [10:0] f);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         txd_pin <= f[i];
         repeat (div - 1) @(posedge ref_clk);
      end
   endtask
   // one 8N1 character off rxd, sampled mid-bit
   task automatic rx_byte(input int div, output logic [7:0] b,
      output logic ok);
      int n = 0;
      while (rxd_pin !== 1'h0 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      ok = n < 30000;
      repeat (div / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (div) @(posedge ref_clk);
         if (i < 8) b[i] = rxd_pin;
      end
      ok = ok && rxd_pin === 1'h1;
   endtask
endmodule // mdp_dte_model
`default_nettype wire

// ==== verification/test_mdp_serial_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_mdp_serial_port;
   import mdp_pkg::*;
   logic ref_clk, rst_n, reg_wr, reg_rd, txd_pin, rts_n_pin, dtr_n_pin;
   logic rxd_pin, cts_n_pin, dsr_n_pin, dcd_n_pin, ri_n_pin, pin_oe, mux_en;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata, reg_rdata, d;
   logic [7:0] b;
   logic ok;
   int fails = 0;
   int n_checks = 0;
   mdp_serial_port dut (.*);
   mdp_dte_model u_dte (.*);
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic s_reset;
      chk({pin_oe, rxd_pin, cts_n_pin, dsr_n_pin, dcd_n_pin, ri_n_pin,
         mux_en}, 7'h6E);
      rd(REG_CTRL);
      chk(d, 32'h00001D17);
      rd(REG_STATUS);
      chk(d[19:15], 5'h01);
      chk(d[4], 1'h0);
   endtask
   task automatic s_cfg;
      for (int i = 0; i < 6; i++) begin
         wr(REG_CTRL, {18'h0, 4'hF, 2'(i % 3), 3'(i), 5'h07});
         rd(REG_CTRL);
         chk(d[9:8], 32'(i % 3));
         rd(REG_STATUS);
         chk(d[14:12], 32'(i));
      end
      wr(REG_CTRL, 32'h00003D00);
      wr(REG_CTRL, 32'h00003D08);
      rd(REG_CTRL);
      chk(d, 32'h00003D07);
      rd(REG_STATUS);
      chk(d[19:8], 12'h687);
      chk(mux_en, 1'h1);
      rd(8'h20);
      chk(d, 32'h0);
   endtask
   task automatic s_lines;
      wr(REG_LINE, 32'h3);
      repeat (3) @(posedge ref_clk);
      chk({dsr_n_pin, dcd_n_pin, ri_n_pin}, 3'h1);
      wr(REG_LINE, 32'h4);
      repeat (3) @(posedge ref_clk);
      chk({dsr_n_pin, dcd_n_pin, ri_n_pin}, 3'h6);
      wr(REG_LINE, 32'h1);
   endtask
   task automatic s_rx;
      u_dte.tx_frame(1085, 10, 11'h278);
      chk(cts_n_pin, 1'h1);
      rd(REG_RXDATA);
      chk(d, 32'h3C);
      wr(REG_CTRL, 32'h00003D27);
      chk(cts_n_pin, 1'h0);
      u_dte.tx_frame(1085, 11, 11'h678);
      rd(REG_STATUS);
      chk(d[3:1], 3'h3);
      wr(REG_CTRL, 32'h00003D07);
   endtask
   task automatic s_tx;
      wr(REG_TXDATA, 32'hA5);
      u_dte.rx_byte(1085, b, ok);
      chk({ok, b}, 9'h1A5);
   endtask
   task automatic s_dtr;
      u_dte.set_dtr(1'h1);
      repeat (10) @(posedge ref_clk);
      rd(REG_STATUS);
      chk(d[7], 1'h1);
      rd(REG_LINE);
      chk({d[0], dsr_n_pin}, 2'h1);
      u_dte.rx_byte(1085, b, ok);
      chk({ok, b}, 9'h10D);
   endtask
   initial begin
      rst_n = 1'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge ref_clk);
      s_reset;
      s_cfg;
      s_lines;
      s_rx;
      s_tx;
      s_dtr;
      conclude;
   end
endmodule // test_mdp_serial_port
`default_nettype wire
